/* dlv_pkg.sv */
// Operation
// - wxga: 1366x768 over one link
// - fhd: two links, master odd, slave even
// - size mode governs receive and transmit
// - single link may use link b
// - dual link master/slave roles swappable
// - video clock from one selected link
// - 8/10 bit; channel 4 unused at 8
// - source meets wxga clock/line/frame ranges
// - source meets fhd clock/line/frame ranges
// - full sync: use and pass syncs
// - de-only: de timing, no sync outputs
// - vesa/jeida mapping for both links, paths
// - reserved bits ignored, syncs don't-care de-only
// - source keeps both links' syncs aligned
// - source starts each line on master
// - de low while syncs rise
package dlv_pkg;

   // ---------------------------------------------------------------
   // link word layout
   // ---------------------------------------------------------------
   localparam int W_LINK   = 35;       // 5 channels of 7 bits
   localparam int W_PIX    = 30;       // r,g,b of 10 bits each
   localparam int W_COL    = 10;
   localparam int POS_MAIN = 0;        // 6 msb/lsb per colour, ch0..2
   localparam int POS_DE   = 18;
   localparam int POS_HS   = 19;
   localparam int POS_VS   = 20;
   localparam int POS_CH3  = 21;       // 2 bits per colour
   localparam int POS_CH4  = 27;       // 2 bits per colour, 10-bit only
   localparam int POS_RSV  = 33;       // reserved, never decoded

   // ---------------------------------------------------------------
   // sync mode settings
   // ---------------------------------------------------------------
   localparam logic       SYNC_MODE_FULL = 1'h1;
   localparam logic       SYNC_MODE_DE   = 1'h0;
   localparam logic [7:0] IN_SYNC_FULL   = 8'h13;
   localparam logic [7:0] IN_SYNC_DE     = 8'h14;
   localparam logic       OUT_SYNC_ON    = 1'h1;
   localparam logic       OUT_SYNC_OFF   = 1'h0;

   // ---------------------------------------------------------------
   // frame timing, per link clock
   // ---------------------------------------------------------------
   localparam logic [11:0] WXGA_HACT = 12'h556;  // 1366
   localparam logic [11:0] WXGA_HTOT = 12'h670;  // 1648
   localparam logic [10:0] WXGA_VACT = 11'h300;  // 768
   localparam logic [10:0] WXGA_VTOT = 11'h346;  // 838
   localparam logic [11:0] FHD_HACT  = 12'h3C0;  // 1920/2
   localparam logic [11:0] FHD_HTOT  = 12'h44C;  // 2200/2
   localparam logic [10:0] FHD_VACT  = 11'h438;  // 1080
   localparam logic [10:0] FHD_VTOT  = 11'h465;  // 1125
   localparam logic [11:0] H_FRONT   = 12'h018;
   localparam logic [11:0] H_WIDTH   = 12'h020;
   localparam logic [10:0] V_FRONT   = 11'h003;
   localparam logic [10:0] V_WIDTH   = 11'h005;
   localparam logic [11:0] HTOT_MAX  = 12'h802;  // 2050, longest line

   // ---------------------------------------------------------------
   // word unpack: {r,g,b,vs,hs,de}, 8-bit left justified
   // ---------------------------------------------------------------
   function automatic logic [W_PIX+2:0] dlv_unpack(
      input logic [W_LINK-1:0] w,
      input logic              jeida,
      input logic              ten);
      logic [5:0]  m;
      logic [1:0]  x3;
      logic [1:0]  x4;
      logic [W_PIX-1:0] pix;
      pix = '0;
      for (int c = 0; c < 3; c++) begin
         m  = w[POS_MAIN+6*c +: 6];
         x3 = w[POS_CH3+2*c +: 2];
         x4 = ten ? w[POS_CH4+2*c +: 2] : 2'h0;   // channel 4 unused at 8
         if (jeida)
            pix[W_COL*c +: W_COL] = {m, x3, x4};
         else if (ten)
            pix[W_COL*c +: W_COL] = {x4, x3, m};
         else
            pix[W_COL*c +: W_COL] = {x3, m, 2'h0};
      end
      return {pix, w[POS_VS], w[POS_HS], w[POS_DE]};
   endfunction

   // ---------------------------------------------------------------
   // word pack, inverse of unpack
   // ---------------------------------------------------------------
   function automatic logic [W_LINK-1:0] dlv_pack(
      input logic [W_PIX-1:0] pix,
      input logic             vs,
      input logic             hs,
      input logic             de,
      input logic             jeida,
      input logic             ten);
      logic [W_COL-1:0]  col;
      logic [W_LINK-1:0] w;
      w = '0;
      for (int c = 0; c < 3; c++) begin
         col = pix[W_COL*c +: W_COL];
         if (jeida) begin
            w[POS_MAIN+6*c +: 6] = col[9:4];
            w[POS_CH3+2*c +: 2]  = col[3:2];
            w[POS_CH4+2*c +: 2]  = ten ? col[1:0] : 2'h0;
         end else if (ten) begin
            w[POS_MAIN+6*c +: 6] = col[5:0];
            w[POS_CH3+2*c +: 2]  = col[7:6];
            w[POS_CH4+2*c +: 2]  = col[9:8];
         end else begin
            w[POS_MAIN+6*c +: 6] = col[7:2];
            w[POS_CH3+2*c +: 2]  = col[9:8];
         end
      end
      w[POS_VS] = vs;
      w[POS_HS] = hs;
      w[POS_DE] = de;
      return w;
   endfunction

endpackage

/* dlv_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dlv_link_if import dlv_pkg::*; ();
   logic              a_clk;   // link a clock
   logic              b_clk;   // link b clock
   logic [W_LINK-1:0] a_word;  // link a deserialized word
   logic [W_LINK-1:0] b_word;  // link b deserialized word

   modport src (output a_clk, output b_clk, output a_word, output b_word);
   modport dev (input a_clk, input b_clk, input a_word, input b_word);
endinterface
`default_nettype wire

/* dlv_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dlv_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;

   // three stage chain, only the second stage reads the first
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // accept a change once stages two and three agree
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         q_ff <= '0;
      else if (s2_ff == s3_ff)
         q_ff <= s3_ff;
   end

   assign q = q_ff;
endmodule // dlv_sync
`default_nettype wire

/* dlv_rx_end.sv */
`timescale 1ns/1ps
`default_nettype none
module dlv_rx_end import dlv_pkg::*; (
   input  wire logic         clock,
   input  wire logic         arst_n,
   dlv_link_if.dev           lnk,
   input  wire logic         mode_fhd,
   input  wire logic         rx_link_role_select,
   input  wire logic         video_clock_link_select,
   input  wire logic         width_10bit,
   input  wire logic         format_jeida,
   input  wire logic         sync_mode,
   input  wire logic [7:0]   input_sync_config_a,
   input  wire logic [7:0]   input_sync_config_b,
   input  wire logic [7:0]   input_sync_config_c,
   input  wire logic         output_sync_config,
   output logic [W_PIX-1:0]  pix_odd,
   output logic [W_PIX-1:0]  pix_even,
   output logic              pix_valid,
   output logic              pix_even_valid,
   output logic              vertical_sync,
   output logic              horizontal_sync,
   output logic              data_enable_strobe,
   output logic              frame_start,
   output logic              line_len_err,
   output logic              sync_cfg_ok,
   output logic              clk_sel_err,
   output logic              tx_mode_fhd,
   output logic              tx_format_jeida,
   output logic              tx_width_10bit
);

   // ---------------------------------------------------------------
   // configuration capture and crossing
   // ---------------------------------------------------------------
   localparam int W_CFG = 32;

   logic [W_CFG-1:0] cfg_ff;
   logic [W_CFG-1:0] cfg_v;
   logic             vclk;

   // configuration registered in the system clock domain
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         cfg_ff <= '0;
      else
         cfg_ff <= {1'b1, mode_fhd, rx_link_role_select, // top bit: loaded
                    video_clock_link_select, width_10bit, format_jeida,
                    sync_mode, input_sync_config_a, input_sync_config_b,
                    input_sync_config_c, output_sync_config};
   end

   // selected link clock; the select is a static strap, change it only
   // while the block is held in reset to avoid a clock glitch
   assign vclk = video_clock_link_select ? lnk.b_clk : lnk.a_clk;

   // configuration level crossing into the video clock domain
   dlv_sync #(.W(W_CFG)) u_cfg_sync (
      .clock  (vclk),
      .arst_n (arst_n),
      .d      (cfg_ff),
      .q      (cfg_v)
   );

   // ---------------------------------------------------------------
   // configuration fields, video domain
   // ---------------------------------------------------------------
   logic       c_live;
   logic       c_fhd;
   logic       c_role_b;
   logic       c_clk_b;
   logic       c_ten;
   logic       c_jeida;
   logic       c_smode;
   logic [7:0] c_in_a;
   logic [7:0] c_in_b;
   logic [7:0] c_in_c;
   logic       c_out;

   assign {c_live, c_fhd, c_role_b, c_clk_b, c_ten, c_jeida, c_smode,
           c_in_a, c_in_b, c_in_c, c_out} = cfg_v;

   // ---------------------------------------------------------------
   // link word capture
   // ---------------------------------------------------------------
   logic [W_LINK-1:0] word_a_ff;
   logic [W_LINK-1:0] word_b_ff;

   // both links sampled on the one video clock edge
   always_ff @(posedge vclk or negedge arst_n) begin
      if (!arst_n) begin
         word_a_ff <= '0;
         word_b_ff <= '0;
      end else begin
         word_a_ff <= lnk.a_word;
         word_b_ff <= lnk.b_word;
      end
   end

   // ---------------------------------------------------------------
   // decode and role selection
   // ---------------------------------------------------------------
   logic [W_PIX+2:0] px_a;
   logic [W_PIX+2:0] px_b;
   logic [W_PIX+2:0] px_m;
   logic [W_PIX+2:0] px_s;
   logic             sync_full;
   logic             sync_de;
   logic             drive_sync;
   logic             m_de;
   logic             m_vs;
   logic             m_hs;

   // unpack with the shared mapping and width for both links
   assign px_a = dlv_unpack(word_a_ff, c_jeida, c_ten);
   assign px_b = dlv_unpack(word_b_ff, c_jeida, c_ten);

   // master carries odd pixels or the single link
   assign px_m = c_role_b ? px_b : px_a;
   assign px_s = c_role_b ? px_a : px_b;

   // sync mode decode from the mode and the sync settings
   assign sync_full = (c_smode == SYNC_MODE_FULL) &&
                      (c_in_a == IN_SYNC_FULL) &&
                      (c_in_b == IN_SYNC_FULL) &&
                      (c_in_c == IN_SYNC_FULL);
   assign sync_de   = (c_smode == SYNC_MODE_DE) &&
                      (c_in_a == IN_SYNC_DE) &&
                      (c_in_b == IN_SYNC_DE) &&
                      (c_in_c == IN_SYNC_DE) &&
                      (c_out == OUT_SYNC_OFF);
   assign drive_sync = sync_full && (c_out == OUT_SYNC_ON);

   // incoming syncs are don't-care outside full sync mode
   assign m_de = px_m[0];
   assign m_hs = sync_full ? px_m[1] : 1'b0;
   assign m_vs = sync_full ? px_m[2] : 1'b0;

   // ---------------------------------------------------------------
   // pixel output stage
   // ---------------------------------------------------------------
   logic [W_PIX-1:0] pix_odd_ff;
   logic [W_PIX-1:0] pix_even_ff;
   logic             pix_valid_ff;
   logic             pix_even_valid_ff;
   logic             vs_ff;
   logic             hs_ff;
   logic             de_ff;

   // odd pixel in the first slot, even pixel in the second
   always_ff @(posedge vclk or negedge arst_n) begin
      if (!arst_n) begin
         pix_odd_ff        <= '0;
         pix_even_ff       <= '0;
         pix_valid_ff      <= 1'b0;
         pix_even_valid_ff <= 1'b0;
      end else begin
         pix_odd_ff        <= m_de ? px_m[W_PIX+2:3] : '0;
         pix_even_ff       <= (c_fhd && m_de) ? px_s[W_PIX+2:3] : '0;
         pix_valid_ff      <= m_de;
         pix_even_valid_ff <= c_fhd && m_de;
      end
   end

   // syncs passed with the video only in full sync mode
   always_ff @(posedge vclk or negedge arst_n) begin
      if (!arst_n) begin
         vs_ff <= 1'b0;
         hs_ff <= 1'b0;
         de_ff <= 1'b0;
      end else begin
         vs_ff <= drive_sync ? m_vs : 1'b0;
         hs_ff <= drive_sync ? m_hs : 1'b0;
         de_ff <= m_de;
      end
   end

   // ---------------------------------------------------------------
   // frame start detection
   // ---------------------------------------------------------------
   logic        vs_d_ff;
   logic        de_d_ff;
   logic [11:0] gap_ff;
   logic        gap_long;
   logic        frame_start_ff;

   assign gap_long = (gap_ff > HTOT_MAX);

   // history of vs and de, and length of the current de-low gap
   always_ff @(posedge vclk or negedge arst_n) begin
      if (!arst_n) begin
         vs_d_ff <= 1'b0;
         de_d_ff <= 1'b0;
         gap_ff  <= '0;
      end else begin
         vs_d_ff <= m_vs;
         de_d_ff <= m_de;
         if (m_de)
            gap_ff <= '0;
         else if (!gap_long)
            gap_ff <= gap_ff + 12'h001;
      end
   end

   // vs rise in full sync, long de gap ended in de-only
   always_ff @(posedge vclk or negedge arst_n) begin
      if (!arst_n)
         frame_start_ff <= 1'b0;
      else if (sync_full)
         frame_start_ff <= m_vs && !vs_d_ff;
      else
         frame_start_ff <= m_de && !de_d_ff && gap_long;
   end

   // ---------------------------------------------------------------
   // active line length check
   // ---------------------------------------------------------------
   logic [11:0] len_ff;
   logic        arm_ff;
   logic        line_len_err_ff;
   logic [11:0] exp_len;

   assign exp_len = c_fhd ? FHD_HACT : WXGA_HACT;

   // count de cycles per line; arm once a de fall is seen on settled
   // config, so a line cut by reset or config latency is not judged
   always_ff @(posedge vclk or negedge arst_n) begin
      if (!arst_n) begin
         len_ff <= '0;
         arm_ff <= 1'b0;
      end else begin
         arm_ff <= arm_ff || (c_live && de_d_ff && !m_de);
         if (m_de)
            len_ff <= len_ff + 12'h001;
         else
            len_ff <= '0;
      end
   end

   // sticky mismatch, a new error beats the frame-start clear
   always_ff @(posedge vclk or negedge arst_n) begin
      if (!arst_n)
         line_len_err_ff <= 1'b0;
      else if (arm_ff && de_d_ff && !m_de && (len_ff != exp_len))
         line_len_err_ff <= 1'b1;
      else if (frame_start_ff)
         line_len_err_ff <= 1'b0;
   end

   // ---------------------------------------------------------------
   // status and transmit-side mode
   // ---------------------------------------------------------------
   logic sync_cfg_ok_ff;
   logic clk_sel_err_ff;
   logic tx_fhd_ff;
   logic tx_jeida_ff;
   logic tx_ten_ff;

   // modes shared with the transmit path
   always_ff @(posedge vclk or negedge arst_n) begin
      if (!arst_n) begin
         sync_cfg_ok_ff <= 1'b0;
         clk_sel_err_ff <= 1'b0;
         tx_fhd_ff      <= 1'b0;
         tx_jeida_ff    <= 1'b0;
         tx_ten_ff      <= 1'b0;
      end else begin
         sync_cfg_ok_ff <= sync_full || sync_de;
         clk_sel_err_ff <= !c_fhd && (c_clk_b != c_role_b);
         tx_fhd_ff      <= c_fhd;
         tx_jeida_ff    <= c_jeida;
         tx_ten_ff      <= c_ten;
      end
   end

   assign pix_odd            = pix_odd_ff;
   assign pix_even           = pix_even_ff;
   assign pix_valid          = pix_valid_ff;
   assign pix_even_valid     = pix_even_valid_ff;
   assign vertical_sync      = vs_ff;
   assign horizontal_sync    = hs_ff;
   assign data_enable_strobe = de_ff;
   assign frame_start        = frame_start_ff;
   assign line_len_err       = line_len_err_ff;
   assign sync_cfg_ok        = sync_cfg_ok_ff;
   assign clk_sel_err        = clk_sel_err_ff;
   assign tx_mode_fhd        = tx_fhd_ff;
   assign tx_format_jeida    = tx_jeida_ff;
   assign tx_width_10bit     = tx_ten_ff;

endmodule // dlv_rx_end
`default_nettype wire

/* dlv_src_end.sv */
`timescale 1ns/1ps
`default_nettype none
module dlv_src_end import dlv_pkg::*; (
   input  wire logic             clock,
   input  wire logic             arst_n,
   dlv_link_if.src               lnk,
   input  wire logic             mode_fhd,
   input  wire logic             role_b_master,
   input  wire logic             width_10bit,
   input  wire logic             format_jeida,
   input  wire logic             de_only,
   input  wire logic [W_PIX-1:0] src_odd,
   input  wire logic [W_PIX-1:0] src_even,
   output logic                  src_take,
   output logic                  src_frame_start
);

   // ---------------------------------------------------------------
   // link clock divider and timing counters
   // ---------------------------------------------------------------
   logic        lclk_ff;
   logic [11:0] hcnt_ff;
   logic [10:0] vcnt_ff;
   logic [11:0] hact;
   logic [11:0] htot;
   logic [10:0] vact;
   logic [10:0] vtot;
   logic        adv;

   assign hact = mode_fhd ? FHD_HACT : WXGA_HACT;
   assign htot = mode_fhd ? FHD_HTOT : WXGA_HTOT;
   assign vact = mode_fhd ? FHD_VACT : WXGA_VACT;
   assign vtot = mode_fhd ? FHD_VTOT : WXGA_VTOT;
   assign adv  = lclk_ff;   // words change at the falling link edge

   // link clock is the system clock halved
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         lclk_ff <= 1'b0;
      else
         lclk_ff <= !lclk_ff;
   end

   // one line and frame counter shared by both links
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hcnt_ff <= '0;
         vcnt_ff <= '0;
      end else if (adv) begin
         if (hcnt_ff >= htot - 12'h001) begin
            hcnt_ff <= '0;
            vcnt_ff <= (vcnt_ff >= vtot - 11'h001) ? '0 : vcnt_ff + 11'h001;
         end else begin
            hcnt_ff <= hcnt_ff + 12'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // sync generation and word packing
   // ---------------------------------------------------------------
   logic              de;
   logic              hs;
   logic              vs;
   logic [W_LINK-1:0] w_m;
   logic [W_LINK-1:0] w_s;

   // syncs rise only in blanking, where de is low
   assign de = (hcnt_ff < hact) && (vcnt_ff < vact);
   assign hs = !de_only && (hcnt_ff >= hact + H_FRONT) &&
               (hcnt_ff < hact + H_FRONT + H_WIDTH);
   assign vs = !de_only && (vcnt_ff >= vact + V_FRONT) &&
               (vcnt_ff < vact + V_FRONT + V_WIDTH);

   assign w_m = dlv_pack(src_odd, vs, hs, de, format_jeida, width_10bit);
   assign w_s = mode_fhd ?
                dlv_pack(src_even, vs, hs, de, format_jeida, width_10bit) :
                '0;

   logic [W_LINK-1:0] a_word_ff;
   logic [W_LINK-1:0] b_word_ff;
   logic              take_ff;
   logic              fs_ff;

   // first pixel on whichever link is master
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         a_word_ff <= '0;
         b_word_ff <= '0;
         take_ff   <= 1'b0;
         fs_ff     <= 1'b0;
      end else begin
         if (adv) begin
            a_word_ff <= role_b_master ? w_s : w_m;
            b_word_ff <= role_b_master ? w_m : w_s;
         end
         take_ff <= adv && de;
         fs_ff   <= adv && (hcnt_ff == '0) && (vcnt_ff == '0);
      end
   end

   assign lnk.a_clk       = lclk_ff;
   assign lnk.b_clk       = lclk_ff;
   assign lnk.a_word      = a_word_ff;
   assign lnk.b_word      = b_word_ff;
   assign src_take        = take_ff;
   assign src_frame_start = fs_ff;

endmodule // dlv_src_end
`default_nettype wire

/* dlv_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dlv_link_monitor import dlv_pkg::*; (
   input wire logic              a_clk,
   input wire logic              b_clk,
   input wire logic [W_LINK-1:0] a_word,
   input wire logic [W_LINK-1:0] b_word,
   input wire logic              arst_n,
   input wire logic              mode_fhd,
   input wire logic              de_only
);
   default clocking cb @(posedge a_clk); endclocking
   default disable iff (!arst_n);
   logic        de, hs, vs, hs_rise;
   logic        up_ff, seen_ff, hs_d_ff;
   logic [11:0] act_ff, tot_ff;
   // ----------------------------------------
   // line timing helpers
   // ----------------------------------------
   // either link may be the master
   assign de = a_word[POS_DE] | b_word[POS_DE];
   assign hs = a_word[POS_HS] | b_word[POS_HS];
   assign vs = a_word[POS_VS] | b_word[POS_VS];
   assign hs_rise = hs & ~hs_d_ff;
   // edge tracking, keeps pre-reset history out
   always_ff @(posedge a_clk or negedge arst_n) begin
      if (!arst_n) begin
         up_ff   <= 1'b0;
         seen_ff <= 1'b0;
         hs_d_ff <= 1'b0;
      end else begin
         up_ff   <= 1'b1;
         seen_ff <= seen_ff | hs_rise;
         hs_d_ff <= hs;
      end
   end
   // active run length
   always_ff @(posedge a_clk or negedge arst_n) begin
      if (!arst_n) act_ff <= 12'h000;
      else act_ff <= de ? act_ff + 12'h001 : 12'h000;
   end
   // line period
   always_ff @(posedge a_clk or negedge arst_n) begin
      if (!arst_n) tot_ff <= 12'h000;
      else tot_ff <= hs_rise ? 12'h001 : tot_ff + 12'h001;
   end
   a_clk_same: assert property (@(negedge a_clk) b_clk)
      else $error("link clocks differ");
   a_hs_rise_de: assert property ((up_ff && !de_only && $rose(hs))
      |-> !de) else $error("de high at hs rise");
   a_vs_rise_de: assert property ((up_ff && !de_only && $rose(vs))
      |-> !de[*8]) else $error("de high at vs rise");
   a_links_aligned: assert property (mode_fhd |->
      a_word[POS_VS:POS_DE] == b_word[POS_VS:POS_DE])
      else $error("link syncs not aligned");
   a_line_active: assert property ((up_ff && $fell(de)) |->
      act_ff == (mode_fhd ? FHD_HACT : WXGA_HACT))
      else $error("wrong active length");
   a_line_total: assert property ((hs_rise && seen_ff) |->
      tot_ff == (mode_fhd ? FHD_HTOT : WXGA_HTOT))
      else $error("wrong line total");
   a_blank_quiet: assert property ((up_ff && $fell(de))
      |-> !de[*8]) else $error("blanking too short");
   a_hs_width: assert property ((up_ff && $rose(hs)) |-> hs[*8])
      else $error("hs pulse too short");
   cover property (up_ff && $fell(de) && mode_fhd);
   cover property (up_ff && $fell(de) && !mode_fhd);
   cover property (hs_rise && seen_ff);
endmodule // dlv_link_monitor
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb import dlv_pkg::*; ();
   localparam logic [W_PIX-1:0] PO = 30'h25A96C3B;
   localparam logic [W_PIX-1:0] PE = 30'h1A5C3B96;
   localparam logic [W_PIX-1:0] M8 = 30'h3FCFF3FC;
   logic             clock = 1'b0;
   logic             arst_n = 1'b0;
   logic             fhd = 1'b0, rb = 1'b0, w10 = 1'b0;
   logic             jd = 1'b0, deo = 1'b0, csel = 1'b0;
   logic [7:0]       scb = 8'h13;
   int               failures = 0;
   int               compares = 0;
   logic [W_PIX-1:0] p_o, p_e;
   logic             pv, pev, vs_o, hs_o, de_o, fs, lerr;
   logic             sok, cerr, t_f, t_j, t_w;
   // {fhd, role b, 10 bit, jeida, de only}
   logic [4:0]       rows [6] = '{5'b00000, 5'b01110, 5'b10100,
                                  5'b11011, 5'b10001, 5'b00101};
   dlv_link_if lnk ();
   dlv_src_end i_dlv_src_end (.clock, .arst_n, .lnk(lnk.src),
      .mode_fhd(fhd), .role_b_master(rb), .width_10bit(w10),
      .format_jeida(jd), .de_only(deo), .src_odd(PO), .src_even(PE),
      .src_take(), .src_frame_start());
   dlv_rx_end i_dlv_rx_end (.clock, .arst_n, .lnk(lnk.dev),
      .mode_fhd(fhd), .rx_link_role_select(rb),
      .video_clock_link_select(csel), .width_10bit(w10),
      .format_jeida(jd), .sync_mode(!deo),
      .input_sync_config_a(deo ? 8'h14 : 8'h13), .input_sync_config_b(scb),
      .input_sync_config_c(deo ? 8'h14 : 8'h13), .output_sync_config(!deo),
      .pix_odd(p_o), .pix_even(p_e), .pix_valid(pv), .pix_even_valid(pev),
      .vertical_sync(vs_o), .horizontal_sync(hs_o),
      .data_enable_strobe(de_o), .frame_start(fs), .line_len_err(lerr),
      .sync_cfg_ok(sok), .clk_sel_err(cerr), .tx_mode_fhd(t_f),
      .tx_format_jeida(t_j), .tx_width_10bit(t_w));
   dlv_link_monitor i_dlv_link_monitor (.a_clk(lnk.a_clk),
      .b_clk(lnk.b_clk), .a_word(lnk.a_word), .b_word(lnk.b_word),
      .arst_n, .mode_fhd(fhd), .de_only(deo));
   // ----------------------------------------
   // clock, tasks
   // ----------------------------------------
   initial forever #5 clock = ~clock;
   // verdict and end of run
   task automatic wrap_up();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // reset with a new setting
   task automatic start(input logic [4:0] r, input logic cs,
                        input logic [7:0] sb);
      @(posedge clock);
      arst_n <= 1'b0;
      {fhd, rb, w10, jd, deo} <= r;
      csel <= cs;
      scb <= sb;
      repeat (8) @(posedge clock);
      `CHK({pv, t_f}, 2'b00)
      arst_n <= 1'b1;
   endtask
   // bounded wait for the valid level
   task automatic wait_pv(input logic v);
      int n;
      n = 0;
      while (pv !== v && n < 6000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 6000) failures++;
   endtask
   // one line: pixels, then syncs in the blank
   task automatic chk_line(input logic ehs, input logic ok, input logic ce);
      logic seen;
      logic quiet;
      seen = 1'b0;
      quiet = 1'b0;
      wait_pv(1'b1);
      `CHK(p_o, w10 ? PO : PO & M8)
      `CHK(p_e, fhd ? (w10 ? PE : PE & M8) : 30'h0)
      `CHK(pev, fhd)
      `CHK(de_o, 1'b1)
      wait_pv(1'b0);
      repeat (300) begin
         @(negedge clock);
         seen |= hs_o;
         quiet |= vs_o | fs;
      end
      `CHK(seen, ehs)
      `CHK(quiet, 1'b0)
      `CHK({sok, cerr, t_f, t_j, t_w}, {ok, ce, fhd, jd, w10})
      if (!fhd) `CHK(lerr, 1'b0)
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      for (int i = 0; i < 6; i++) begin
         start(rows[i], rows[i][3], rows[i][0] ? 8'h14 : 8'h13);
         wait_pv(1'b1);
         wait_pv(1'b0);
         repeat (2) chk_line(!rows[i][0], 1'b1, 1'b0);
         $display("row %0d done", i);
      end
      // clock on the idle link, mixed sync setting
      start(5'b00000, 1'b1, 8'h14);
      wait_pv(1'b1);
      wait_pv(1'b0);
      chk_line(1'b0, 1'b0, 1'b1);
      $display("mismatch test done");
      wrap_up();
   end
   // watchdog
   initial begin
      repeat (80000) @(posedge clock);
      failures++;
      wrap_up();
   end
endmodule // tb
`default_nettype wire
